// ==== pdc_config.sv ====
// pll divider configuration logic with reference, loop and output dividers
`timescale 1ns/1ps
// Contract
// - crystal reference divided by sixteen to form phase detector reference.
// - vco runs at loop divisor times divided reference; loop divider to detector.
// - output divider ratio 1,2,4,8 for select 00,01,10,11.
// - output divider gives 50% duty cycle at ratios 2,4,8; ratio 1 passes the source through with its own duty.
// - rising parallel strobe captures loop divisor and output select.
// - parallel strobe low makes parallel latches transparent.
// - parallel path overrides serial; serial loads only with strobe high.
// - 14-bit shift register shifts one bit per serial clock rise.
// - stream order probe select, output select, loop divisor.
// - each field sent most significant bit first.
// - serial latch falling edge with strobe high transfers shift register.
// - parallel strobe low forces probe select to 000.
// - probe output shows node chosen by probe select, serial only.
// - probe select 110 bypasses pll, serial clock feeds both dividers.
module pdc_config
   import pdc_pkg::*;
(
   input  wire logic                      clk_sys,
   input  wire logic                      sys_rst,
   input  wire logic                      clkEn,
   input  wire logic                      crystalRef,
   input  wire logic                      vcoClk,
   input  wire logic                      parallelLoadStrobe,
   input  wire logic [pdc_pkg::LOOP_W-1:0] loopDivisorIn,
   input  wire logic [pdc_pkg::ODIV_W-1:0] outputDivideSelectIn,
   input  wire logic                      serialShiftClock,
   input  wire logic                      serialDataIn,
   input  wire logic                      serialLatchStrobe,
   output logic                           refClk,
   output logic                           loopFeedback,
   output logic                           synthOut,
   output logic                           probeOut,
   output logic [pdc_pkg::LOOP_W-1:0]     loopDivisor,
   output logic [pdc_pkg::ODIV_W-1:0]     outputDivideSelect,
   output logic [pdc_pkg::PROBE_W-1:0]    probeSelect
);
   import pdc_pkg::*;

   typedef struct packed {
      logic [1:0]  plsSync;
      logic [1:0]  sclkSync;
      logic [1:0]  sdatSync;
      logic [1:0]  slatSync;
      logic [1:0]  xtalSync;
      logic [1:0]  vcoSync;
      logic        plsPrev;
      logic        sclkPrev;
      logic        slatPrev;
      logic        xtalPrev;
      logic        srcPrev;
      logic [3:0]  refCnt;
      logic        refOut;
      logic [8:0]  loopCnt;
      logic        loopOut;
      logic [2:0]  outCnt;
      logic        synth;
      logic        probe;
      logic [13:0] shift;
      logic [8:0]  loopDiv;
      logic [1:0]  odivSel;
      logic [2:0]  probeSel;
      pdc_mode_e   mode;
   } pdc_state_s;

   pdc_state_s stQ;
   pdc_state_s stD;

   // toggle counter terminal count for a select code
   function automatic logic [2:0] odivTop(input logic [1:0] sel);
      case (sel)
         2'h0:    odivTop = 3'h0;
         2'h1:    odivTop = 3'h0;
         2'h2:    odivTop = 3'h1;
         default: odivTop = 3'h3;
      endcase
   endfunction

   logic pls;
   logic sclk;
   logic sdat;
   logic slat;
   logic src;
   logic srcRise;

   always_comb
   begin
      stD = stQ;
      pls = stQ.plsSync[1];
      sclk = stQ.sclkSync[1];
      sdat = stQ.sdatSync[1];
      slat = stQ.slatSync[1];
      src = (stQ.mode == PDC_BYP) ? sclk : stQ.vcoSync[1];
      srcRise = src & ~stQ.srcPrev;
      stD.plsSync = {stQ.plsSync[0], parallelLoadStrobe};
      stD.sclkSync = {stQ.sclkSync[0], serialShiftClock};
      stD.sdatSync = {stQ.sdatSync[0], serialDataIn};
      stD.slatSync = {stQ.slatSync[0], serialLatchStrobe};
      stD.xtalSync = {stQ.xtalSync[0], crystalRef};
      stD.vcoSync = {stQ.vcoSync[0], vcoClk};
      stD.plsPrev = pls;
      stD.sclkPrev = sclk;
      stD.slatPrev = slat;
      stD.xtalPrev = stQ.xtalSync[1];
      stD.srcPrev = src;
      // reference divider, toggle every 8 rises gives /16
      if (stQ.xtalSync[1] & ~stQ.xtalPrev)
      begin
         stD.refCnt = stQ.refCnt + 4'h1;
         if (stQ.refCnt == 4'(REF_DIV / 2 - 1))
         begin
            stD.refCnt = 4'h0;
            stD.refOut = ~stQ.refOut;
         end
      end
      // shift register, msb first into top field
      if (sclk & ~stQ.sclkPrev)
         stD.shift = {stQ.shift[12:0], sdat};
      if (!pls)
      begin
         stD.loopDiv = loopDivisorIn;
         stD.odivSel = outputDivideSelectIn;
         stD.probeSel = PROBE_RST;
      end
      else if (!stQ.plsPrev)
      begin
         stD.loopDiv = loopDivisorIn;
         stD.odivSel = outputDivideSelectIn;
      end
      else if (stQ.slatPrev & ~slat)
      begin
         stD.probeSel = stQ.shift[PROBE_MSB_POS -: 3];
         stD.odivSel = stQ.shift[ODIV_MSB_POS -: 2];
         stD.loopDiv = stQ.shift[LOOP_MSB_POS:0];
      end
      stD.mode = (stQ.probeSel == PROBE_BYPASS) ? PDC_BYP : PDC_RUN;
      // loop divider: one feedback pulse per loopDiv source rises
      if (srcRise)
      begin
         stD.loopCnt = stQ.loopCnt + 9'h1;
         stD.loopOut = 1'b0;
         if (stQ.loopCnt + 9'h1 >= stQ.loopDiv)
         begin
            stD.loopCnt = 9'h0;
            stD.loopOut = 1'b1;
         end
      end
      // output divider, pass-through at select 00, else toggle-based for 50% duty
      if (stQ.odivSel == 2'h0)
         stD.synth = src;
      else if (srcRise)
      begin
         stD.outCnt = stQ.outCnt + 3'h1;
         if (stQ.outCnt >= odivTop(stQ.odivSel))
         begin
            stD.outCnt = 3'h0;
            stD.synth = ~stQ.synth;
         end
      end
      case (stQ.probeSel)
         PROBE_SHIFT:  stD.probe = stQ.shift[SHIFT_W-1];
         PROBE_HIGH:   stD.probe = 1'b1;
         PROBE_REF:    stD.probe = stQ.refOut;
         PROBE_LOOP:   stD.probe = stQ.loopOut;
         PROBE_OUT:    stD.probe = stQ.synth;
         PROBE_BYPASS: stD.probe = stQ.loopOut;
         PROBE_OUT4:   stD.probe = stQ.outCnt[1];
         default:      stD.probe = 1'b0;
      endcase
      if (!pls)
         stD.probe = 1'b0;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         stQ <= '0;
         stQ.loopDiv <= LOOP_RST;
         stQ.odivSel <= ODIV_RST;
         stQ.probeSel <= PROBE_RST;
         stQ.shift <= SHIFT_RST;
         stQ.mode <= PDC_RUN;
      end
      else if (clkEn)
         stQ <= stD;
   end

   always_comb
   begin
      refClk = stQ.refOut;
      loopFeedback = stQ.loopOut;
      synthOut = stQ.synth;
      probeOut = stQ.probe;
      loopDivisor = stQ.loopDiv;
      outputDivideSelect = stQ.odivSel;
      probeSelect = stQ.probeSel;
   end

   property p_probe_forced;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && !stQ.plsSync[1] |=> probeSelect == PROBE_RST;
   endproperty
   a_probe_forced: assert property (p_probe_forced)
      else $error("probe select not forced low");

   property p_serial_load;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && stQ.plsSync[1] && stQ.plsPrev && stQ.slatPrev
         && !stQ.slatSync[1]
      |=> loopDivisor == $past(stQ.shift[8:0])
         && probeSelect == $past(stQ.shift[13:11]);
   endproperty
   a_serial_load: assert property (p_serial_load)
      else $error("serial transfer wrong");

   property p_hold;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && stQ.plsSync[1] && stQ.plsPrev
         && !(stQ.slatPrev && !stQ.slatSync[1])
      |=> $stable(loopDivisor) && $stable(probeSelect);
   endproperty
   a_hold: assert property (p_hold)
      else $error("active values changed while shifting");

   property p_par_capture;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && !stQ.plsSync[1]
      |=> loopDivisor == $past(loopDivisorIn);
   endproperty
   a_par_capture: assert property (p_par_capture)
      else $error("parallel latch not transparent");

   property p_shift;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && stQ.sclkSync[1] && !stQ.sclkPrev
      |=> stQ.shift[0] == $past(stQ.sdatSync[1]);
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift register missed bit");

   property p_bypass;
      @(posedge clk_sys) disable iff (sys_rst)
      clkEn && probeSelect == PROBE_BYPASS |=> stQ.mode == PDC_BYP;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass mode not entered");
endmodule

// ==== pdc_host_model.sv ====
// host model driving the parallel and serial configuration pins
`timescale 1ns/1ps
module pdc_host_model
   import pdc_pkg::*;
(
   input  wire logic                  clk_sys,
   output logic                       parallelLoadStrobe,
   output logic [pdc_pkg::LOOP_W-1:0] loopDivisorIn,
   output logic [pdc_pkg::ODIV_W-1:0] outputDivideSelectIn,
   output logic                       serialShiftClock,
   output logic                       serialDataIn,
   output logic                       serialLatchStrobe
);
   initial
   begin
      parallelLoadStrobe = 1'b0;
      loopDivisorIn = LOOP_RST;
      outputDivideSelectIn = ODIV_RST;
      serialShiftClock = 1'b0;
      serialDataIn = 1'b0;
      serialLatchStrobe = 1'b0;
   end
   // each pin level held three cycles
   task automatic hold();
      repeat (3) @(negedge clk_sys);
   endtask
   task automatic par_load(input logic [8:0] m, input logic [1:0] n);
      parallelLoadStrobe = 1'b0;
      loopDivisorIn = m;
      outputDivideSelectIn = n;
      hold();
      parallelLoadStrobe = 1'b1;
      hold();
   endtask
   // probe, output select, loop fields, msb first
   task automatic shift(input logic [13:0] w);
      for (int i = 13; i >= 0; i--)
      begin
         serialDataIn = w[i];
         hold();
         serialShiftClock = 1'b1;
         hold();
         serialShiftClock = 1'b0;
         serialDataIn = ~w[i];
         hold();
      end
   endtask
   // pulse only after a full word
   task automatic latch();
      serialLatchStrobe = 1'b1;
      hold();
      serialLatchStrobe = 1'b0;
      hold();
   endtask
endmodule

// ==== pdc_pkg.sv ====
// shared constants for the pll divider configuration logic
package pdc_pkg;
   localparam int unsigned REF_DIV         = 16;
   localparam int unsigned LOOP_W          = 9;
   localparam int unsigned ODIV_W          = 2;
   localparam int unsigned PROBE_W         = 3;
   localparam int unsigned SHIFT_W         = 14;
   localparam int unsigned PROBE_MSB_POS   = 13;
   localparam int unsigned ODIV_MSB_POS    = 10;
   localparam int unsigned LOOP_MSB_POS    = 8;
   localparam logic [2:0] PROBE_RST        = 3'h0;
   localparam logic [2:0] PROBE_BYPASS     = 3'h6;
   localparam logic [2:0] PROBE_REF        = 3'h2;
   localparam logic [2:0] PROBE_LOOP       = 3'h3;
   localparam logic [2:0] PROBE_OUT        = 3'h4;
   localparam logic [2:0] PROBE_OUT4       = 3'h7;
   localparam logic [2:0] PROBE_SHIFT      = 3'h0;
   localparam logic [2:0] PROBE_HIGH       = 3'h1;
   localparam logic [8:0] LOOP_RST         = 9'h0C8;
   localparam logic [1:0] ODIV_RST         = 2'h0;
   localparam logic [13:0] SHIFT_RST       = 14'h0000;
   localparam logic [8:0] LOOP_MIN_LOCK    = 9'h0C8;
   localparam logic [8:0] LOOP_MAX_LOCK    = 9'h190;
   typedef enum logic [1:0] {PDC_RUN = 2'h0, PDC_BYP = 2'h1} pdc_mode_e;
endpackage

// ==== tb.sv ====
// self-checking testbench for the pll divider configuration logic
`timescale 1ns/1ps
module tb;
   import pdc_pkg::*;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       clkEn = 1'b1;
   logic       crystalRef = 1'b0;
   logic       vcoClk = 1'b0;
   logic       parallelLoadStrobe, serialShiftClock, serialDataIn;
   logic       serialLatchStrobe, refClk, loopFeedback, synthOut;
   logic       probeOut, outPrev, refPrev;
   logic       loopPrev, probePrev;
   logic [8:0] loopDivisorIn, loopDivisor;
   logic [1:0] outputDivideSelectIn, outputDivideSelect;
   logic [2:0] probeSelect;
   logic [13:0] act;
   int         error_cnt = 0, compares = 0, outRises = 0, refRises = 0;
   int         loopRises = 0, probeRises = 0, outHigh = 0;
   int         o0, r0, l0, p0, h0;
   assign act = {probeSelect, outputDivideSelect, loopDivisor};
   always #2.5 clk_sys = ~clk_sys;
   pdc_config dut_u (
      .clk_sys              (clk_sys),
      .sys_rst              (sys_rst),
      .clkEn                (clkEn),
      .crystalRef           (crystalRef),
      .vcoClk               (vcoClk),
      .parallelLoadStrobe   (parallelLoadStrobe),
      .loopDivisorIn        (loopDivisorIn),
      .outputDivideSelectIn (outputDivideSelectIn),
      .serialShiftClock     (serialShiftClock),
      .serialDataIn         (serialDataIn),
      .serialLatchStrobe    (serialLatchStrobe),
      .refClk               (refClk),
      .loopFeedback         (loopFeedback),
      .synthOut             (synthOut),
      .probeOut             (probeOut),
      .loopDivisor          (loopDivisor),
      .outputDivideSelect   (outputDivideSelect),
      .probeSelect          (probeSelect)
   );
   pdc_host_model host_u (
      .clk_sys              (clk_sys),
      .parallelLoadStrobe   (parallelLoadStrobe),
      .loopDivisorIn        (loopDivisorIn),
      .outputDivideSelectIn (outputDivideSelectIn),
      .serialShiftClock     (serialShiftClock),
      .serialDataIn         (serialDataIn),
      .serialLatchStrobe    (serialLatchStrobe)
   );
   // edge and level counters, sampled where outputs are settled
   always @(negedge clk_sys)
   begin
      outPrev <= synthOut;
      refPrev <= refClk;
      loopPrev <= loopFeedback;
      probePrev <= probeOut;
      if (synthOut === 1'b1)
         outHigh <= outHigh + 1;
      if (synthOut === 1'b1 && outPrev === 1'b0)
         outRises <= outRises + 1;
      if (refClk === 1'b1 && refPrev === 1'b0)
         refRises <= refRises + 1;
      if (loopFeedback === 1'b1 && loopPrev === 1'b0)
         loopRises <= loopRises + 1;
      if (probeOut === 1'b1 && probePrev === 1'b0)
         probeRises <= probeRises + 1;
   end
   task automatic check(input logic [13:0] got, input logic [13:0] exp,
                        input int tol);
      compares++;
      if ($isunknown(got) || (tol == 0 ? got !== exp
          : got > exp + tol || got + tol < exp))
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic settle();
      repeat (6) @(negedge clk_sys);
   endtask
   // source clocks toggled with eight-cycle period
   task automatic run_src(input int n, input logic [2:0] mask);
      o0 = outRises;
      r0 = refRises;
      l0 = loopRises;
      p0 = probeRises;
      h0 = outHigh;
      repeat (n)
      begin
         {vcoClk, crystalRef, host_u.serialShiftClock} = mask;
         repeat (4) @(negedge clk_sys);
         {vcoClk, crystalRef, host_u.serialShiftClock} = 3'h0;
         repeat (4) @(negedge clk_sys);
      end
      settle();
   endtask
   initial
   begin
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      settle();
      check(act, {3'h0, 2'h0, 9'h0C8}, 0);
      host_u.loopDivisorIn = 9'h12C;
      settle();
      check(act, {3'h0, 2'h0, 9'h12C}, 0);
      host_u.par_load(9'h106, 2'h2);
      host_u.loopDivisorIn = 9'h15E;
      settle();
      check(act, {3'h0, 2'h2, 9'h106}, 0);
      host_u.shift({3'h3, 2'h1, 9'h190});
      check(act, {3'h0, 2'h2, 9'h106}, 0);
      host_u.latch();
      settle();
      check(act, {3'h3, 2'h1, 9'h190}, 0);
      host_u.parallelLoadStrobe = 1'b0;
      settle();
      check(act, {3'h0, 2'h2, 9'h15E}, 0);
      check(14'(probeOut), 14'h0, 0);
      host_u.shift({3'h7, 2'h3, 9'h0C8});
      host_u.latch();
      settle();
      check(act, {3'h0, 2'h2, 9'h15E}, 0);
      for (int n = 0; n < 4; n++)
      begin
         host_u.par_load(9'h0C8, 2'(n));
         run_src(400, 3'h6);
         check(14'(outRises - o0), 14'(400 >> n), 1);
         check(14'(outHigh - h0), 14'h640, 40);
         check(14'(refRises - r0), 14'h19, 1);
         check(14'(loopRises - l0), 14'h2, 1);
      end
      host_u.shift({3'h6, 2'h1, 9'h0C8});
      host_u.latch();
      // serial clock only: counts prove the bypass source
      run_src(400, 3'h1);
      check(14'(outRises - o0), 14'hC8, 1);
      check(14'(probeRises - p0), 14'h2, 1);
      clkEn = 1'b0;
      host_u.shift({3'h1, 2'h0, 9'h0C8});
      host_u.latch();
      check(act, {3'h6, 2'h1, 9'h0C8}, 0);
      clkEn = 1'b1;
      host_u.shift({3'h1, 2'h0, 9'h0C8});
      host_u.latch();
      settle();
      check(act, {3'h1, 2'h0, 9'h0C8}, 0);
      check(14'(probeOut), 14'h1, 0);
      report_and_stop();
   end
endmodule
